// >>> hw/dpm_params.svh
// Named constants for the output pin multiplexer and host bus block.
// Assumes inclusion by bare name from the design files only.
`ifndef DPM_PARAMS_SVH
`define DPM_PARAMS_SVH

// Width of the host data bus and of the register address.
`define DPM_DATA_W 8
`define DPM_ADDR_W 4
// Number of general output pins.
`define DPM_PIN_COUNT 8
// Level of every output pin while master reset is asserted.
`define DPM_PIN_RESET_LEVEL 8'hFF
// Reset value of the data bus output register.
`define DPM_DATA_RESET 8'h00
// Level driven by an open-drain pin when it pulls low.
`define DPM_OD_LOW 1'b0
// Pin positions that carry alternate functions in this block.
`define DPM_PIN_RTS_B 1
`define DPM_PIN_CLK_B 3
`define DPM_PIN_RX_B 5
`define DPM_PIN_TX_A 6
`define DPM_PIN_TX_B 7

`endif

// >>> hw/dpm_pkg.sv
// Types shared by the output pin multiplexer and its testbench.
// Assumes the constants header is compiled alongside.
package dpm_pkg;

    // Source choices for general output pin three.
    typedef enum logic [1:0]
    {
        DPM_P3_GENERAL = 2'b00,
        DPM_P3_TX_CLK = 2'b01,
        DPM_P3_RX_CLK = 2'b10,
        DPM_P3_CT_READY = 2'b11
    } dpm_pin3_sel_type;

    // Source choices for general output pin five.
    typedef enum logic [1:0]
    {
        DPM_P5_GENERAL = 2'b00,
        DPM_P5_RX_READY = 2'b01,
        DPM_P5_RX_FULL = 2'b10
    } dpm_pin5_sel_type;

endpackage

// >>> hw/dpm_reg_store.sv
// Small register store written and read by the host bus logic.
// Assumes one clock, synchronous active-high reset, write and read same
// clock; read data appear one edge after the address.
`timescale 1ns/1ps
`include "dpm_params.svh"

module dpm_reg_store
#(
    parameter int ADDR_W = `DPM_ADDR_W,
    parameter int DATA_W = `DPM_DATA_W
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data_ff
);

    logic [DATA_W-1:0] mem_ff [2**ADDR_W];

    // The store needs at least one address bit and one data bit.
    if (ADDR_W < 1 || DATA_W < 1)
    begin : g_bad_params
        $error("dpm_reg_store: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////
    // One flip-flop word per entry, cleared by reset so reads never see X.
    for (genvar i = 0; i < 2**ADDR_W; i++)
    begin : g_word
        always_ff @(posedge sys_clk)
        begin
            if (reset)
                mem_ff[i] <= '0;
            else if (wr_en && wr_addr == ADDR_W'(i))
                mem_ff[i] <= wr_data;
        end
    end

    // Registered read port keeps the bus output timing clean.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rd_data_ff <= '0;
        else
            rd_data_ff <= mem_ff[rd_addr];
    end

endmodule // dpm_reg_store

// >>> hw/dpm_pin_mux.sv
// Output pin multiplexer, host data bus driver and interrupt request pin.
// Assumes host strobes and all sources are synchronous to sys_clk, and
// that pad logic resolves each output and enable pair onto the wire.
//
// How it works
// - Pin one may carry channel B request-to-send instead of its value.
// - Pin three may carry B transmit or receive clock, or timer ready.
// - Pin five may be an open-drain B receiver ready or FIFO full flag.
// - Pin seven may be an open-drain channel B transmitter ready flag.
// - Pin six may be an open-drain channel A transmitter ready flag.
// - The data bus is released while deselected, bar a Z-mode acknowledge.
// - The interrupt request pulls low while any enabled cause is present.
// - The interrupt request stays low until every enabled cause is gone.
// - A selected write stores the bus at the write strobe's rising edge.
// - A selected read drives the addressed register onto the data bus.
// - All eight output pins are high while master reset is asserted.
`timescale 1ns/1ps
`include "dpm_params.svh"

module dpm_pin_mux
#(
    parameter int PIN_COUNT = `DPM_PIN_COUNT,
    parameter int ADDR_W = `DPM_ADDR_W,
    parameter int DATA_W = `DPM_DATA_W
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out_ff,
    output logic data_oe_ff,
    input wire logic interrupt_acknowledge_cycle,
    input wire logic z_mode,
    input wire logic [DATA_W-1:0] int_vector,
    input wire logic [PIN_COUNT-1:0] gen_out_value,
    input wire logic pin1_rts_sel,
    input wire dpm_pkg::dpm_pin3_sel_type pin3_sel,
    input wire dpm_pkg::dpm_pin5_sel_type pin5_sel,
    input wire logic pin6_tx_ready_sel,
    input wire logic pin7_tx_ready_sel,
    input wire logic chan_b_request_to_send_n,
    input wire logic chan_b_tx_clock_x1,
    input wire logic chan_b_rx_clock_x1,
    input wire logic counter_ready_n,
    input wire logic chan_b_rx_ready_n,
    input wire logic chan_b_rx_fifo_full_n,
    input wire logic chan_b_tx_ready_n,
    input wire logic chan_a_tx_ready_n,
    input wire logic [7:0] int_condition,
    input wire logic [7:0] int_mask,
    output logic [PIN_COUNT-1:0] gen_out_ff,
    output logic [PIN_COUNT-1:0] gen_out_oe_ff,
    output logic interrupt_request_n_ff,
    output logic interrupt_request_oe_ff
);

    // Only the documented pin count and an eight-bit bus are served, since
    // the reset constants and the interrupt vector are eight bits wide.
    if (PIN_COUNT != `DPM_PIN_COUNT || ADDR_W < 1
        || DATA_W != `DPM_DATA_W)
    begin : g_bad_params
        $error("dpm_pin_mux: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin source selection. Open-drain choices drive only when pulling low.
    logic [PIN_COUNT-1:0] nxt_gen_out;
    logic [PIN_COUNT-1:0] nxt_gen_out_oe;
    logic chan_b_rx_ready_or_full_n;
    logic pin3_level;
    logic pin3_is_od;

    assign chan_b_rx_ready_or_full_n = (pin5_sel == dpm_pkg::DPM_P5_RX_FULL)
        ? chan_b_rx_fifo_full_n : chan_b_rx_ready_n;
    assign pin3_level =
        (pin3_sel == dpm_pkg::DPM_P3_TX_CLK) ? chan_b_tx_clock_x1 :
        (pin3_sel == dpm_pkg::DPM_P3_RX_CLK) ? chan_b_rx_clock_x1 :
        (pin3_sel == dpm_pkg::DPM_P3_CT_READY) ? `DPM_OD_LOW :
        gen_out_value[`DPM_PIN_CLK_B];
    assign pin3_is_od = (pin3_sel == dpm_pkg::DPM_P3_CT_READY);

    // Unselected pins fall through to their general value, push-pull.
    always_comb
    begin
        nxt_gen_out = gen_out_value;
        nxt_gen_out_oe = '1;
        if (pin1_rts_sel)
            nxt_gen_out[`DPM_PIN_RTS_B] = chan_b_request_to_send_n;
        nxt_gen_out[`DPM_PIN_CLK_B] = pin3_level;
        if (pin3_is_od)
            nxt_gen_out_oe[`DPM_PIN_CLK_B] = ~counter_ready_n;
        if (pin5_sel != dpm_pkg::DPM_P5_GENERAL)
        begin
            nxt_gen_out[`DPM_PIN_RX_B] = `DPM_OD_LOW;
            nxt_gen_out_oe[`DPM_PIN_RX_B] = ~chan_b_rx_ready_or_full_n;
        end
        if (pin6_tx_ready_sel)
        begin
            nxt_gen_out[`DPM_PIN_TX_A] = `DPM_OD_LOW;
            nxt_gen_out_oe[`DPM_PIN_TX_A] = ~chan_a_tx_ready_n;
        end
        if (pin7_tx_ready_sel)
        begin
            nxt_gen_out[`DPM_PIN_TX_B] = `DPM_OD_LOW;
            nxt_gen_out_oe[`DPM_PIN_TX_B] = ~chan_b_tx_ready_n;
        end
    end

    // Reset forces every pin high and driven.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            gen_out_ff <= `DPM_PIN_RESET_LEVEL;
            gen_out_oe_ff <= '1;
        end
        else
        begin
            gen_out_ff <= nxt_gen_out;
            gen_out_oe_ff <= nxt_gen_out_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request: a level, never latched here, so it releases only
    // once every unmasked cause has been cleared at its source.
    logic int_pending;

    assign int_pending = |(int_condition & int_mask);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            interrupt_request_n_ff <= 1'b1;
            interrupt_request_oe_ff <= 1'b0;
        end
        else
        begin
            interrupt_request_n_ff <= ~int_pending;
            interrupt_request_oe_ff <= int_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host bus. The write commits on the strobe's rising edge using the
    // address and data held in the last cycle the strobe was low, so a
    // bus that changes right at the edge is not sampled.
    logic wr_active;
    logic rd_active;
    logic ack_active;
    logic wr_commit;
    logic nxt_data_oe;
    logic [DATA_W-1:0] nxt_data_out;
    logic wr_active_ff;
    logic [ADDR_W-1:0] wr_addr_ff;
    logic [DATA_W-1:0] wr_data_ff;
    logic [DATA_W-1:0] rd_data_ff;

    assign wr_active = ~wr_n & ~cs_n;
    assign rd_active = ~rd_n & ~cs_n;
    assign ack_active = interrupt_acknowledge_cycle & z_mode;
    assign wr_commit = wr_active_ff & wr_n;
    assign nxt_data_oe = rd_active | ack_active;
    assign nxt_data_out = ack_active ? int_vector : rd_data_ff;

    // Capture the write address and data while the strobe is low.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wr_active_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= '0;
        end
        else
        begin
            wr_active_ff <= wr_active;
            if (wr_active)
            begin
                wr_addr_ff <= addr;
                wr_data_ff <= data_in;
            end
        end
    end

    // Bus output stage; released whenever select is high and no acknowledge.
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            data_out_ff <= `DPM_DATA_RESET;
            data_oe_ff <= 1'b0;
        end
        else
        begin
            data_out_ff <= nxt_data_out;
            data_oe_ff <= nxt_data_oe;
        end
    end

    dpm_reg_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_store
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_commit),
        .wr_addr(wr_addr_ff),
        .wr_data(wr_data_ff),
        .rd_addr(addr),
        .rd_data_ff(rd_data_ff)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks on the pins this block drives.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_rts_pin_follow: assert property (
        pin1_rts_sel |=> gen_out_ff[`DPM_PIN_RTS_B] ==
            $past(chan_b_request_to_send_n))
        else $error("pin one does not follow request-to-send");
    a_timer_ready_od: assert property (
        pin3_sel == dpm_pkg::DPM_P3_CT_READY |=>
            gen_out_oe_ff[`DPM_PIN_CLK_B] == !$past(counter_ready_n)
            && gen_out_ff[`DPM_PIN_CLK_B] == 1'b0)
        else $error("pin three timer ready drive wrong");
    a_rx_flag_od: assert property (
        pin5_sel == dpm_pkg::DPM_P5_RX_FULL |=>
            gen_out_oe_ff[`DPM_PIN_RX_B] == !$past(chan_b_rx_fifo_full_n))
        else $error("pin five FIFO full drive wrong");
    a_txb_ready_od: assert property (
        pin7_tx_ready_sel |=>
            gen_out_oe_ff[`DPM_PIN_TX_B] == !$past(chan_b_tx_ready_n))
        else $error("pin seven ready drive wrong");
    a_txa_ready_od: assert property (
        pin6_tx_ready_sel |=>
            gen_out_oe_ff[`DPM_PIN_TX_A] == !$past(chan_a_tx_ready_n))
        else $error("pin six ready drive wrong");
    a_bus_released: assert property (
        cs_n && !(interrupt_acknowledge_cycle && z_mode) |=> !data_oe_ff)
        else $error("data bus driven while deselected");
    a_irq_asserts: assert property (
        |(int_condition & int_mask) |=> interrupt_request_oe_ff
            && !interrupt_request_n_ff)
        else $error("interrupt request not asserted");
    a_irq_holds: assert property (
        $fell(interrupt_request_oe_ff) |-> $past(int_condition & int_mask)
            == '0)
        else $error("interrupt request released early");
    a_read_returns: assert property (
        wr_commit ##2 (rd_active && addr == $past(wr_addr_ff)
            && !ack_active)[*2] |=> data_out_ff == $past(wr_data_ff, 4))
        else $error("read does not return written data");
    a_general_follow: assert property (
        !pin1_rts_sel |=> gen_out_ff[0] == $past(gen_out_value[0])
            && gen_out_ff[`DPM_PIN_RTS_B] ==
            $past(gen_out_value[`DPM_PIN_RTS_B]))
        else $error("general pin does not follow its value");
    // The default disable would silence this check, so it is switched off.
    a_reset_high: assert property (
        @(posedge sys_clk) disable iff (1'b0)
        reset |=> gen_out_ff == `DPM_PIN_RESET_LEVEL)
        else $error("pins not high after reset");

    c_host_write: cover property (wr_commit);
    c_vector_ack: cover property (ack_active ##1 data_oe_ff);
    c_irq_cycle: cover property (int_pending ##[1:20] !int_pending);

endmodule // dpm_pin_mux

// >>> test/dpm_host_model.sv
// Host processor model: drives chip select, strobes, address and data.
// Assumes its tasks are called at a falling edge of sys_clk.
`timescale 1ns/1ps

module dpm_host_model
(
    input wire logic sys_clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out_ff,
    input wire logic data_oe_ff
);
    logic drive = 1'b0;
    logic [7:0] host_data = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Wire level; a released bus shows the inverse of the last host byte
    // so that a stale value can never pass for a driven one.
    assign data_in = drive ? host_data :
                     (data_oe_ff ? data_out_ff : ~host_data);

    // Idle bus: nothing selected, both strobes high.
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
    end

    // Write: strobe low with select, then a rising strobe commits; the
    // next call may start at the following falling edge.
    task write(input logic [3:0] a, input logic [7:0] d, input logic sel_n);
        @(negedge sys_clk);
        cs_n = sel_n;
        wr_n = 1'b0;
        addr = a;
        host_data = d;
        drive = 1'b1;
        @(negedge sys_clk);
        wr_n = 1'b1;
        @(negedge sys_clk);
        cs_n = 1'b1;
        drive = 1'b0;
    endtask

    // Read: held three cycles so that the registered data has landed.
    task read(input logic [3:0] a, input logic sel_n,
              output logic [7:0] d, output logic oe);
        @(negedge sys_clk);
        cs_n = sel_n;
        rd_n = 1'b0;
        addr = a;
        repeat (3) @(negedge sys_clk);
        d = data_in;
        oe = data_oe_ff;
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask
endmodule // dpm_host_model

// >>> test/dpm_pin_mux_tb.sv
// Self-checking bench for the output pin multiplexer and host bus block.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps

`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("[FAIL] %0t got %h exp %h", $time, g, e); \
        end \
    end

module dpm_pin_mux_tb;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n, rd_n, wr_n, data_oe_ff, interrupt_request_n_ff;
    logic [3:0] addr;
    logic [7:0] data_in, data_out_ff, gen_out_ff, gen_out_oe_ff, rd_d;
    logic interrupt_request_oe_ff, rd_oe;
    logic interrupt_acknowledge_cycle = 1'b0;
    logic z_mode = 1'b0;
    logic [7:0] int_vector = 8'h96;
    logic [7:0] gen_out_value = 8'h00;
    logic pin1_rts_sel = 1'b0;
    dpm_pkg::dpm_pin3_sel_type pin3_sel = dpm_pkg::DPM_P3_GENERAL;
    dpm_pkg::dpm_pin5_sel_type pin5_sel = dpm_pkg::DPM_P5_GENERAL;
    logic pin6_tx_ready_sel = 1'b0;
    logic pin7_tx_ready_sel = 1'b0;
    logic chan_b_request_to_send_n = 1'b1;
    logic chan_b_tx_clock_x1 = 1'b0;
    logic chan_b_rx_clock_x1 = 1'b1;
    logic counter_ready_n = 1'b1;
    logic chan_b_rx_ready_n = 1'b1;
    logic chan_b_rx_fifo_full_n = 1'b1;
    logic chan_b_tx_ready_n = 1'b1;
    logic chan_a_tx_ready_n = 1'b1;
    logic [7:0] int_condition = 8'h00;
    logic [7:0] int_mask = 8'h00;

    dpm_pin_mux dpm_pin_mux_inst (.*);
    dpm_host_model dpm_host_model_inst (.*);

    ////////////////////////////////////////////////////////////////////
    // Clock of 10 ns, and a cycle ceiling far above the test length.
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One cycle later a pin must show the level and enable expected.
    task pin(input int p, input logic lv, input logic oe);
        @(negedge sys_clk);
        `CHK(gen_out_ff[p], lv)
        `CHK(gen_out_oe_ff[p], oe)
    endtask

    // Every alternate source of every pin, with the general value set
    // against each push-pull source's level so that a wrong selection shows.
    task t_alt;
        gen_out_value = 8'hFF;
        pin1_rts_sel = 1'b1;
        chan_b_request_to_send_n = 1'b0;
        pin(1, 1'b0, 1'b1);
        pin1_rts_sel = 1'b0;
        pin(1, 1'b1, 1'b1);
        pin3_sel = dpm_pkg::DPM_P3_TX_CLK;
        pin(3, 1'b0, 1'b1);
        gen_out_value = 8'h00;
        pin3_sel = dpm_pkg::DPM_P3_RX_CLK;
        pin(3, 1'b1, 1'b1);
        pin3_sel = dpm_pkg::DPM_P3_CT_READY;
        counter_ready_n = 1'b0;
        pin(3, 1'b0, 1'b1);
        counter_ready_n = 1'b1;
        pin(3, 1'b0, 1'b0);
        pin5_sel = dpm_pkg::DPM_P5_RX_READY;
        chan_b_rx_ready_n = 1'b0;
        pin(5, 1'b0, 1'b1);
        chan_b_rx_ready_n = 1'b1;
        chan_b_rx_fifo_full_n = 1'b0;
        pin(5, 1'b0, 1'b0);
        pin5_sel = dpm_pkg::DPM_P5_RX_FULL;
        pin(5, 1'b0, 1'b1);
        pin5_sel = dpm_pkg::dpm_pin5_sel_type'(2'h3);
        pin(5, 1'b0, 1'b0);
        pin6_tx_ready_sel = 1'b1;
        pin7_tx_ready_sel = 1'b1;
        chan_a_tx_ready_n = 1'b0;
        pin(6, 1'b0, 1'b1);
        pin(7, 1'b0, 1'b0);
        chan_a_tx_ready_n = 1'b1;
        chan_b_tx_ready_n = 1'b0;
        pin(7, 1'b0, 1'b1);
        pin(6, 1'b0, 1'b0);
        pin3_sel = dpm_pkg::DPM_P3_GENERAL;
        pin6_tx_ready_sel = 1'b0;
        gen_out_value = 8'h48;
        pin(6, 1'b1, 1'b1);
        pin(3, 1'b1, 1'b1);
    endtask

    // Back-to-back writes, one without select, then reads of both; the
    // first read starts two cycles after the last write commits.
    task t_bus;
        dpm_host_model_inst.write(4'h3, 8'hA5, 1'b0);
        dpm_host_model_inst.write(4'h3, 8'hFF, 1'b1);
        dpm_host_model_inst.write(4'hC, 8'h3C, 1'b0);
        dpm_host_model_inst.read(4'hC, 1'b0, rd_d, rd_oe);
        `CHK(rd_d, 8'h3C)
        dpm_host_model_inst.read(4'h3, 1'b0, rd_d, rd_oe);
        `CHK(rd_d, 8'hA5)
        `CHK(rd_oe, 1'b1)
        repeat (2) @(negedge sys_clk);
        `CHK(data_oe_ff, 1'b0)
        dpm_host_model_inst.read(4'h3, 1'b1, rd_d, rd_oe);
        `CHK(rd_oe, 1'b0)
    endtask

    // Acknowledge drives the vector only in Z mode, select high.
    task t_ack;
        z_mode = 1'b1;
        interrupt_acknowledge_cycle = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK(data_oe_ff, 1'b1)
        `CHK(data_out_ff, 8'h96)
        z_mode = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(data_oe_ff, 1'b0)
        interrupt_acknowledge_cycle = 1'b0;
    endtask

    // Request held until the last enabled condition goes away.
    task t_irq;
        int_mask = 8'h06;
        int_condition = 8'h01;
        repeat (2) @(negedge sys_clk);
        `CHK(interrupt_request_oe_ff, 1'b0)
        int_condition = 8'h07;
        repeat (2) @(negedge sys_clk);
        `CHK({interrupt_request_oe_ff, interrupt_request_n_ff}, 2'h2)
        int_condition = 8'h04;
        repeat (5) @(negedge sys_clk);
        `CHK(interrupt_request_n_ff, 1'b0)
        int_condition = 8'h00;
        repeat (2) @(negedge sys_clk);
        `CHK({interrupt_request_oe_ff, interrupt_request_n_ff}, 2'h1)
    endtask

    // Report the counts and the verdict, then stop.
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Reset for five cycles, the scenarios, then a reset in mid-run.
    initial
    begin
        repeat (3) @(negedge sys_clk);
        `CHK(gen_out_ff, 8'hFF)
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        t_alt();
        t_bus();
        t_ack();
        t_irq();
        gen_out_value = 8'h00;
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK(gen_out_ff, 8'hFF)
        give_verdict();
    end
endmodule // dpm_pin_mux_tb
